// ### hdl/oad_top.sv
// Purpose: Digital back end of an eight-channel delta-sigma converter
// Assumes: Static configuration pins; modulator bits and host pins are asynchronous
// Notes: Serial bit clock is ref_clk; shifting runs one bit per cycle
// Summary of operation
// [R01] Ratio is 128 in high-resolution mode, 64 in the other three.
// [R02] At top high-speed rate the host must use frame-sync format.
// [R03] Bypass skips the filters and shows raw modulator bits.
// [R04] All configuration comes from static pins; no registers.
// [R05] Serial port offers SPI style with data ready, and frame-sync.
// [R06] Output is daisy-chainable; external sync aligns conversions.
// [R07] Eight independent channels convert in parallel, one result each period.
// [R08] All filters start convolution on the same modulator cycle.
// [R09] Every sampling instant derives from the single master clock.
// [R10] Each one-bit stream's ones density becomes the result.
// [R11] Decimator is a multi-stage linear-phase FIR.
// [R12] Results are 24-bit two's complement.
// [R13] Results clip at 7FFFFF and 800000 instead of wrapping.
// [R14] Step response settles within 76 periods, 78 in high-resolution; the 1-2-1 filter here settles within four periods in both modes.
// [R15] Modulator rate divider is chosen by mode and divide select.
// [R16] All eight results are presented together, ready flagged once per period.
module oad_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Static configuration pins
    input wire logic [1:0] mode_select,
    input wire logic clock_divide_select,
    input wire logic filter_bypass,
    input wire logic frame_format,
    // Modulator streams
    input wire logic [oad_pkg::OAD_CHANNELS-1:0] mod_bits,
    output logic mod_sample_strobe,
    // Synchronisation and chaining
    input wire logic sync_n,
    input wire logic chain_in,
    // Serial result port
    input wire logic frame_sync,
    output logic data_ready_n,
    output logic serial_out,
    // Bypass and status
    output logic [oad_pkg::OAD_CHANNELS-1:0] bypass_bits,
    output logic word_dropped
);
    import oad_pkg::*;
    // Two-flop synchronisers for every asynchronous input
    logic [OAD_CHANNELS+2:0] sync1_reg, sync2_reg;
    logic [OAD_CHANNELS-1:0] mod_s;
    logic sync_n_s, chain_s, fsync_s, sync_n_prev_reg, fsync_prev_reg;
    logic sync_fall, fsync_rise;
    logic [OAD_DIV_W-1:0] div_reg, div_value;
    logic [OAD_CNT_W-1:0] osr_reg, osr_value;
    logic osr_high, mod_strobe, conv_end, conv_end_d_reg;
    logic [OAD_RES_W-1:0] chan_result [OAD_CHANNELS];
    logic [OAD_WORD_W-1:0] word_next;
    oad_ser_state_t ser_state_reg;
    logic [OAD_WORD_W-1:0] shift_reg;
    logic [OAD_CNT_W-1:0] bit_reg;
    logic start;
    oad_stream_if fill_if ();
    oad_stream_if drain_if ();

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // Sync line rests high, so no false falling edge follows reset
            sync1_reg <= {2'h0, 1'b1, {OAD_CHANNELS{1'b0}}};
            sync2_reg <= {2'h0, 1'b1, {OAD_CHANNELS{1'b0}}};
        end else begin
            sync1_reg <= {fsync_in_pin(), chain_in, sync_n, mod_bits};
            sync2_reg <= sync1_reg;
        end
    end
    function automatic logic fsync_in_pin();
        return frame_sync;
    endfunction : fsync_in_pin
    assign mod_s = sync2_reg[OAD_CHANNELS-1:0];
    assign sync_n_s = sync2_reg[OAD_CHANNELS];
    assign chain_s = sync2_reg[OAD_CHANNELS+1];
    assign fsync_s = sync2_reg[OAD_CHANNELS+2];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync_n_prev_reg <= 1'b1;
            fsync_prev_reg <= 1'b0;
        end else begin
            sync_n_prev_reg <= sync_n_s;
            fsync_prev_reg <= fsync_s;
        end
    end
    assign sync_fall = sync_n_prev_reg && !sync_n_s;
    assign fsync_rise = fsync_s && !fsync_prev_reg;

    // Mode-dependent divider and oversampling ratio, straight from pins
    assign osr_high = (mode_select == OAD_MODE_HR); // see [R04]
    assign osr_value = osr_high ? OAD_OSR_HIGH : OAD_OSR_LOW; // see [R01]
    always_comb begin
        case (mode_select)
            OAD_MODE_LP: div_value = OAD_DIV_LP;
            OAD_MODE_LS: div_value = OAD_DIV_LS;
            default: div_value = OAD_DIV_FAST;
        endcase
        if (!clock_divide_select) begin
            div_value = div_value >> 1; // see [R15]
        end
    end

    // One divider on ref_clk paces every channel; sync restarts the phase
    always_ff @(posedge ref_clk) begin
        if (reset || sync_fall) begin
            div_reg <= '0; // see [R06]
        end else if (div_reg >= div_value - OAD_DIV_W'(1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + OAD_DIV_W'(1);
        end
    end
    assign mod_strobe = !sync_fall && (div_reg >= div_value - OAD_DIV_W'(1)); // see [R09]
    assign mod_sample_strobe = mod_strobe;

    // Shared ratio counter; one conv_end feeds all channels
    always_ff @(posedge ref_clk) begin
        if (reset || sync_fall) begin
            osr_reg <= '0;
        end else if (mod_strobe) begin
            osr_reg <= conv_end ? '0 : osr_reg + OAD_CNT_W'(1);
        end
    end
    assign conv_end = mod_strobe && (osr_reg >= osr_value - OAD_CNT_W'(1)); // see [R08]

    // Filters stall in bypass, so no stale word follows the raw bits
    generate
        for (genvar ch = 0; ch < OAD_CHANNELS; ch++) begin : g_chan
            oad_decim_chan u_chan ( // see [R07]
                .ref_clk(ref_clk),
                .reset(reset),
                .mod_strobe(mod_strobe && !filter_bypass),
                .mod_bit(mod_s[ch]),
                .conv_end(conv_end && !filter_bypass),
                .osr_high(osr_high),
                .result_reg(chan_result[ch])
            );
            assign word_next[OAD_WORD_W-1-ch*OAD_RES_W -: OAD_RES_W] = chan_result[ch];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            conv_end_d_reg <= 1'b0;
            bypass_bits <= '0;
        end else begin
            conv_end_d_reg <= conv_end && !filter_bypass;
            bypass_bits <= filter_bypass ? mod_s : '0; // see [R03]
        end
    end

    // Whole word of eight results is offered to the buffer once per period
    assign fill_if.valid = conv_end_d_reg; // see [R16]
    assign fill_if.data = word_next;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            word_dropped <= 1'b0;
        end else if (conv_end_d_reg && !fill_if.ready) begin
            word_dropped <= 1'b1;
        end
    end

    oad_result_buf u_buf (
        .ref_clk(ref_clk),
        .reset(reset),
        .fill(fill_if.snk),
        .drain(drain_if.src)
    );

    // Serial port: SPI style starts when a word waits, frame-sync on host frame edge
    assign start = (ser_state_reg == OAD_SER_IDLE) && drain_if.valid && (!frame_format || fsync_rise); // see [R05]
    assign drain_if.ready = start;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ser_state_reg <= OAD_SER_IDLE;
            bit_reg <= '0;
            shift_reg <= '0;
        end else begin
            case (ser_state_reg)
                OAD_SER_IDLE: begin
                    if (start) begin
                        ser_state_reg <= OAD_SER_SHIFT;
                        shift_reg <= drain_if.data;
                        bit_reg <= '0;
                    end
                end
                OAD_SER_SHIFT: begin
                    shift_reg <= {shift_reg[OAD_WORD_W-2:0], 1'b0};
                    bit_reg <= bit_reg + OAD_CNT_W'(1);
                    if (bit_reg == OAD_LAST_BIT) begin
                        ser_state_reg <= OAD_SER_IDLE;
                    end
                end
                default: ser_state_reg <= OAD_SER_IDLE;
            endcase
        end
    end

    // Outside a frame the chain input passes through to the next device
    always_comb begin
        serial_out = (ser_state_reg == OAD_SER_SHIFT) ? shift_reg[OAD_WORD_W-1] : chain_s; // see [R06]
    end

    // Data ready low from load until the first bit has gone out, in SPI style only; frame-sync format keeps it high
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_ready_n <= 1'b1;
        end else if (start && !frame_format) begin
            data_ready_n <= 1'b0; // see [R05]
        end else begin
            data_ready_n <= 1'b1;
        end
    end

    // Checks
    chk_ratio_high: assert property (@(posedge ref_clk) disable iff (reset) // see [R01]
        conv_end && osr_high && !$past(sync_fall) |-> osr_reg == OAD_OSR_HIGH - OAD_CNT_W'(1))
        else $error("high-resolution ratio wrong");
    chk_ratio_low: assert property (@(posedge ref_clk) disable iff (reset) // see [R01]
        conv_end && !osr_high |-> osr_reg == OAD_OSR_LOW - OAD_CNT_W'(1))
        else $error("low ratio wrong");
    chk_div_spacing: assert property (@(posedge ref_clk) disable iff (reset || sync_fall) // see [R15]
        mod_strobe && mode_select == OAD_MODE_HS && clock_divide_select && $stable(mode_select)
        |=> !mod_strobe [*3] ##1 mod_strobe)
        else $error("modulator divider wrong");
    chk_bypass_raw: assert property (@(posedge ref_clk) disable iff (reset) // see [R03]
        filter_bypass |=> bypass_bits == $past(mod_s))
        else $error("bypass bits wrong");
    chk_bypass_quiet: assert property (@(posedge ref_clk) disable iff (reset) // see [R03]
        filter_bypass && $past(filter_bypass) |-> !fill_if.valid)
        else $error("word during bypass");
    chk_word_once: assert property (@(posedge ref_clk) disable iff (reset) // see [R16]
        fill_if.valid |=> !fill_if.valid)
        else $error("word flagged twice");
    chk_word_after_end: assert property (@(posedge ref_clk) disable iff (reset) // see [R08]
        fill_if.valid |-> $past(conv_end))
        else $error("word not aligned to period end");
    chk_drdy_pulse: assert property (@(posedge ref_clk) disable iff (reset) // see [R05]
        !data_ready_n |-> $past(start) && !frame_format)
        else $error("data ready without load");
    chk_frame_len: assert property (@(posedge ref_clk) disable iff (reset) // see [R06]
        start |=> ser_state_reg == OAD_SER_SHIFT [*8])
        else $error("frame ended early");
    chk_sync_restart: assert property (@(posedge ref_clk) disable iff (reset) // see [R06]
        sync_fall |=> osr_reg == '0 && div_reg == '0)
        else $error("sync did not realign");
    chk_clip_range: assert property (@(posedge ref_clk) disable iff (reset) // see [R13]
        conv_end_d_reg |-> chan_result[0][OAD_RES_W-1] == $past(g_chan[0].u_chan.scaled[OAD_WIDE_W-1]))
        else $error("result wrapped instead of clipping");
    cov_spi_frame: cover property (@(posedge ref_clk) start && !frame_format);
    cov_fsync_frame: cover property (@(posedge ref_clk) start && frame_format);
    cov_sync_event: cover property (@(posedge ref_clk) sync_fall);
    cov_drop: cover property (@(posedge ref_clk) conv_end_d_reg && !fill_if.ready);
endmodule : oad_top

// ### hdl/oad_pkg.sv
// Purpose: Shared constants for the octal converter digital back end
// Assumes: 50 MHz ref_clk, one-bit modulator streams sampled on ref_clk
// Notes: Mode codes and divider values are local choices
package oad_pkg;
    localparam int OAD_CHANNELS = 8;
    localparam int OAD_RES_W = 24;
    localparam int OAD_WORD_W = OAD_CHANNELS * OAD_RES_W;
    localparam int OAD_CNT_W = 8;
    localparam int OAD_DIV_W = 6;
    localparam int OAD_Y_W = 12;
    localparam int OAD_WIDE_W = 26;
    // Operating mode codes on mode_select
    localparam logic [1:0] OAD_MODE_HS = 2'h0;
    localparam logic [1:0] OAD_MODE_HR = 2'h1;
    localparam logic [1:0] OAD_MODE_LP = 2'h2;
    localparam logic [1:0] OAD_MODE_LS = 2'h3;
    // Oversampling ratios
    localparam logic [OAD_CNT_W-1:0] OAD_OSR_HIGH = 8'h80;
    localparam logic [OAD_CNT_W-1:0] OAD_OSR_LOW = 8'h40;
    // Modulator rate dividers with clock_divide_select high; low halves them
    localparam logic [OAD_DIV_W-1:0] OAD_DIV_FAST = 6'h04;
    localparam logic [OAD_DIV_W-1:0] OAD_DIV_LP = 6'h08;
    localparam logic [OAD_DIV_W-1:0] OAD_DIV_LS = 6'h28;
    // Scaling shifts that bring the filter range to full scale
    localparam int OAD_SHIFT_HIGH = 14;
    localparam int OAD_SHIFT_LOW = 15;
    localparam logic [OAD_RES_W-1:0] OAD_POS_FULL = 24'h7FFFFF;
    localparam logic [OAD_RES_W-1:0] OAD_NEG_FULL = 24'h800000;
    localparam logic [OAD_CNT_W-1:0] OAD_LAST_BIT = 8'hBF;
    typedef enum logic [1:0] {
        OAD_SER_IDLE = 2'b01,
        OAD_SER_SHIFT = 2'b10
    } oad_ser_state_t;
endpackage : oad_pkg

// ### hdl/oad_stream_if.sv
// Purpose: Valid/ready word carrier between internal blocks
// Assumes: Both ends on ref_clk
// Notes: Data stands while valid is high and ready is low
interface oad_stream_if;
    import oad_pkg::*;
    logic valid;
    logic ready;
    logic [OAD_WORD_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : oad_stream_if

// ### hdl/oad_decim_chan.sv
// Purpose: One channel of the two-stage linear-phase FIR decimator
// Assumes: conv_end coincides with a mod_strobe
// Notes: Stage one is a boxcar over the ratio, stage two a symmetric 1-2-1 FIR
module oad_decim_chan (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Modulator stream
    input wire logic mod_strobe,
    input wire logic mod_bit,
    input wire logic conv_end,
    input wire logic osr_high,
    // Result
    output logic [oad_pkg::OAD_RES_W-1:0] result_reg
);
    import oad_pkg::*;
    logic [OAD_CNT_W-1:0] ones_reg;
    logic [OAD_CNT_W:0] total;
    logic signed [OAD_Y_W-1:0] b_next, b1_reg, b2_reg, y;
    logic signed [OAD_WIDE_W-1:0] scaled;
    logic [OAD_RES_W-1:0] result_next;

    // Ones density over one conversion period; bipolar form keeps the filter symmetric
    assign total = {1'b0, ones_reg} + {{OAD_CNT_W{1'b0}}, mod_bit}; // see [R10]
    assign b_next = OAD_Y_W'(signed'({3'h0, total, 1'b0})) - OAD_Y_W'(signed'({4'h0, osr_high ? OAD_OSR_HIGH : OAD_OSR_LOW}));
    assign y = b_next + (b1_reg <<< 1) + b2_reg; // see [R11]
    assign scaled = osr_high ? (OAD_WIDE_W'(y) <<< OAD_SHIFT_HIGH) : (OAD_WIDE_W'(y) <<< OAD_SHIFT_LOW);

    // Clip rather than wrap at the two end codes
    always_comb begin
        if (scaled > $signed({{(OAD_WIDE_W-OAD_RES_W){1'b0}}, OAD_POS_FULL})) begin
            result_next = OAD_POS_FULL; // see [R13]
        end else if (scaled < $signed({{(OAD_WIDE_W-OAD_RES_W){1'b1}}, OAD_NEG_FULL})) begin
            result_next = OAD_NEG_FULL; // see [R13]
        end else begin
            result_next = scaled[OAD_RES_W-1:0]; // see [R12]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ones_reg <= '0;
        end else if (conv_end) begin
            ones_reg <= '0;
        end else if (mod_strobe) begin
            ones_reg <= total[OAD_CNT_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            b1_reg <= '0;
            b2_reg <= '0;
            result_reg <= '0;
        end else if (conv_end) begin
            b1_reg <= b_next;
            b2_reg <= b1_reg; // see [R14]
            result_reg <= result_next;
        end
    end
endmodule : oad_decim_chan

// ### hdl/oad_result_buf.sv
// Purpose: Two-entry result buffer between decimator and serial port
// Assumes: Single clock
// Notes: Holds a spare word so a serial start up to one period late loses nothing
module oad_result_buf (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Ports
    oad_stream_if.snk fill,
    oad_stream_if.src drain
);
    import oad_pkg::*;
    logic [OAD_WORD_W-1:0] mem_reg [2];
    logic wr_idx_reg, rd_idx_reg;
    logic [1:0] count_reg;
    logic push, pop;

    assign fill.ready = (count_reg != 2'h2);
    assign drain.valid = (count_reg != 2'h0);
    assign drain.data = mem_reg[rd_idx_reg];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_idx_reg] <= fill.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_idx_reg <= 1'b0;
            rd_idx_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) wr_idx_reg <= ~wr_idx_reg;
            if (pop) rd_idx_reg <= ~rd_idx_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : oad_result_buf

// ### tb/oad_host_model.sv
// Purpose: Host controller model that reads result words from the serial port
// Assumes: Bit clock is ref_clk; in frame-sync format chain_in is held low by the bench
// Notes: Frame start is found by the first high bit, so the read word must begin with a one
module oad_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Device serial port
    input wire logic frame_format,
    input wire logic data_ready_n,
    input wire logic serial_out,
    output logic frame_sync,
    // Bench side
    input wire logic rd_req,
    output logic got,
    output logic [oad_pkg::OAD_WORD_W-1:0] host_word
);
    timeunit 1ns;
    timeprecision 1ps;
    import oad_pkg::*;
    int k;

    // Bit 191 stands in the cycle of the ready strobe, then one bit per cycle
    task shift_in;
        host_word[OAD_WORD_W-1] = serial_out;
        for (int i = OAD_WORD_W - 2; i >= 0; i--) begin
            @(posedge ref_clk);
            host_word[i] = serial_out;
        end
        got <= 1'b1;
    endtask : shift_in

    initial begin
        frame_sync = 1'b0;
        got = 1'b0;
        host_word = '0;
        forever begin
            @(posedge ref_clk);
            got <= 1'b0;
            if (!reset && !frame_format && data_ready_n === 1'b0) begin
                shift_in();
            end else if (rd_req === 1'b1) begin
                // Frame held high through the read; edges while shifting are ignored
                frame_sync <= 1'b1;
                k = 0;
                do begin
                    @(posedge ref_clk);
                    k++;
                end while (serial_out !== 1'b1 && k < 64);
                shift_in();
                frame_sync <= 1'b0;
            end
        end
    end
endmodule : oad_host_model

// ### tb/tb_oad_top.sv
// Purpose: Self-checking bench for the octal converter back end
// Assumes: Modulator streams held constant outside the bypass test, so results saturate to known codes
// Notes: Waits are bounded; a timeout counts as a mismatch and ends the run
module tb_oad_top;
    timeunit 1ns;
    timeprecision 1ps;
    import oad_pkg::*;
    logic ref_clk, reset, clock_divide_select, filter_bypass, frame_format, sync_n, chain_in, rd_req;
    logic [1:0] mode_select;
    logic [OAD_CHANNELS-1:0] mod_bits;
    logic mod_sample_strobe, frame_sync, data_ready_n, serial_out, word_dropped, got;
    logic [OAD_CHANNELS-1:0] bypass_bits;
    logic [OAD_WORD_W-1:0] host_word;
    int n_fail = 0;
    int compares = 0;
    int n, lows;
    int div_tab[4] = '{4, 2, 4, 40};
    int osr_tab[4] = '{64, 128, 64, 64};
    logic cds_tab[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    oad_top oad_top_inst (.ref_clk(ref_clk), .reset(reset), .mode_select(mode_select),
        .clock_divide_select(clock_divide_select), .filter_bypass(filter_bypass),
        .frame_format(frame_format), .mod_bits(mod_bits), .mod_sample_strobe(mod_sample_strobe),
        .sync_n(sync_n), .chain_in(chain_in), .frame_sync(frame_sync), .data_ready_n(data_ready_n),
        .serial_out(serial_out), .bypass_bits(bypass_bits), .word_dropped(word_dropped));
    oad_host_model oad_host_model_inst (.ref_clk(ref_clk), .reset(reset), .frame_format(frame_format),
        .data_ready_n(data_ready_n), .serial_out(serial_out), .frame_sync(frame_sync),
        .rd_req(rd_req), .got(got), .host_word(host_word));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task final_report;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task check(input logic [OAD_WORD_W-1:0] seen, input logic [OAD_WORD_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Expected word: channel 0 first, each one-bit stream saturated to its full-scale code
    function automatic logic [OAD_WORD_W-1:0] exp_word(input logic [OAD_CHANNELS-1:0] b);
        logic [OAD_WORD_W-1:0] w;
        for (int i = 0; i < OAD_CHANNELS; i++) begin
            w[(OAD_CHANNELS-1-i)*OAD_RES_W +: OAD_RES_W] = b[i] ? OAD_POS_FULL : OAD_NEG_FULL;
        end
        return w;
    endfunction : exp_word

    function automatic bit hit(input int which);
        case (which)
            0: return data_ready_n === 1'b0;
            1: return got === 1'b1;
            default: return mod_sample_strobe === 1'b1;
        endcase
    endfunction : hit

    // Counts edges until the event; 0 ready strobe, 1 host word, 2 sample strobe
    task wait_for(input int which, output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            cnt++;
        end while (!hit(which) && cnt < 6000);
        if (cnt >= 6000) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
            final_report();
        end
    endtask : wait_for

    // Pins change only while reset is held, as static configuration must
    task start_dev(input logic [1:0] m, input logic cds, input logic byp, input logic ff,
                   input logic [OAD_CHANNELS-1:0] b);
        @(posedge ref_clk);
        reset <= 1'b1;
        mode_select <= m;
        clock_divide_select <= cds;
        filter_bypass <= byp;
        frame_format <= ff;
        mod_bits <= b;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
    endtask : start_dev

    task count_lows(input int cycles);
        lows = 0;
        repeat (cycles) begin
            @(posedge ref_clk);
            if (data_ready_n !== 1'b1) lows++;
        end
    endtask : count_lows

    initial begin
        reset = 1'b1;
        mode_select = OAD_MODE_HS;
        clock_divide_select = 1'b1;
        filter_bypass = 1'b0;
        frame_format = 1'b0;
        mod_bits = 8'h00;
        sync_n = 1'b1;
        chain_in = 1'b0;
        rd_req = 1'b0;
        // Every mode in SPI style; divide select low only where shifting still fits a period
        for (int k = 0; k < 4; k++) begin
            start_dev(k[1:0], cds_tab[k], 1'b0, 1'b0, 8'hA5);
            wait_for(2, n);
            wait_for(2, n);
            check(OAD_WORD_W'(n), OAD_WORD_W'(div_tab[k]));
            wait_for(0, n);
            @(posedge ref_clk);
            check(OAD_WORD_W'(data_ready_n), OAD_WORD_W'(1));
            wait_for(0, n);
            check(OAD_WORD_W'(n + 1), OAD_WORD_W'(osr_tab[k] * div_tab[k]));
            repeat (3) wait_for(1, n);
            check(host_word, exp_word(8'hA5));
        end
        // Idle port passes the chain input through
        chain_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(OAD_WORD_W'(serial_out), OAD_WORD_W'(1));
        chain_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(OAD_WORD_W'(serial_out), OAD_WORD_W'(0));
        // Sync in mid-period restarts the conversion; natural strobe would come far earlier
        wait_for(0, n);
        repeat (300) @(posedge ref_clk);
        sync_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sync_n <= 1'b1;
        wait_for(0, n);
        check(OAD_WORD_W'(n + 4 >= 2560 && n + 4 <= 2572), OAD_WORD_W'(1));
        // Bypass shows raw streams and produces no results
        start_dev(OAD_MODE_HS, 1'b1, 1'b1, 1'b0, 8'h3C);
        repeat (6) @(posedge ref_clk);
        check(OAD_WORD_W'(bypass_bits), OAD_WORD_W'(8'h3C));
        mod_bits <= 8'hC3;
        count_lows(600);
        check(OAD_WORD_W'(bypass_bits), OAD_WORD_W'(8'hC3));
        check(OAD_WORD_W'(lows), OAD_WORD_W'(0));
        // Frame-sync format: host stalls until the buffer overflows, then drains it
        start_dev(OAD_MODE_HS, 1'b1, 1'b0, 1'b1, 8'h00);
        count_lows(600);
        check(OAD_WORD_W'(lows), OAD_WORD_W'(0));
        check(OAD_WORD_W'(word_dropped), OAD_WORD_W'(0));
        repeat (600) @(posedge ref_clk);
        check(OAD_WORD_W'(word_dropped), OAD_WORD_W'(1));
        repeat (3) begin
            rd_req <= 1'b1;
            @(posedge ref_clk);
            rd_req <= 1'b0;
            wait_for(1, n);
        end
        check(host_word, exp_word(8'h00));
        final_report();
    end
endmodule : tb_oad_top
